// [hw/pmcc_pkg.sv]
/*
  Constants, register map and types of the eight-macrocell logic array
  with its configuration and state control.
  Assumes a 25 MHz APB clock; every module but pmcc_pins imports the whole package.
*/
package pmcc_pkg;

  // Array shape
  localparam int NUM_MC = 8;
  localparam int NUM_IN = 12;
  localparam int NUM_LIT = 20;
  localparam int PT_W = 40;
  localparam int PT_PER_MC = 8;
  localparam int NUM_PT = 64;
  localparam int PT_IDX_W = 6;
  localparam int SYNC_W = 42;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MC_FUNC = 8'h04;
  localparam logic [7:0] OFS_PT_INDEX = 8'h08;
  localparam logic [7:0] OFS_PT_LO = 8'h0c;
  localparam logic [7:0] OFS_PT_HI = 8'h10;
  localparam logic [7:0] OFS_PRELOAD = 8'h14;
  localparam logic [7:0] OFS_SIG_LO = 8'h18;
  localparam logic [7:0] OFS_SIG_HI = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SECURE_BIT = 2;
  localparam int PT_HI_EN_BIT = 8;
  localparam int ST_SECURE_BIT = 0;
  localparam int ST_PWRUP_BIT = 1;
  localparam int ST_REFUSED_BIT = 2;

  // Reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [15:0] MC_FUNC_RST = 16'hffff;
  localparam logic [63:0] SIG_RST = 64'h0;

  // Power-up reset interval, typical figure used as the least hold time
  localparam int CLK_PERIOD_NS = 40;
  localparam int POWERUP_RESET_INTERVAL_NS = 600;
  localparam int POWERUP_RESET_INTERVAL_MAX_NS = 1000;
  localparam int PWRUP_CYC_INT =
    (POWERUP_RESET_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] PWRUP_CYC = 5'(PWRUP_CYC_INT);

  typedef enum logic [1:0] {
    MODE_SIMPLE,
    MODE_COMPLEX,
    MODE_REGISTERED
  } pmcc_mode_t;

  typedef enum logic [1:0] {
    FN_REG,
    FN_COMB_IO,
    FN_COMB_OUT,
    FN_INPUT
  } pmcc_func_t;

endpackage

// [hw/pmcc_array.sv]
/*
  Eight-macrocell logic array with APB configuration: product-term
  fuse store, per-cell function, global mode, power-up register clear,
  preload, security bit and user signature.
  Assumes external pins asynchronous to pclk; the register clock pin is
  sampled and edge-detected, so it must run well below pclk/4.
*/
// Notes on behaviour
// R1: Macrocell registers clear low at power-up, clocklessly.
// R2: Registered outputs read high after power-up.
// R3: Power-up interval 600 ns typical, 1000 max.
// R4: Register clock stays still during power-up interval.
// R5: Setup met before first register clock edge.
// R6: Preload forces each register high or low.
// R7: 64-bit signature always readable, even secured.
// R8: Secured device refuses verify readback and preload.
// R9: Security bit acts at once; program last.
// R10: Undriven inputs and I/Os pull high.
// R11: Each cell: registered, comb I/O, comb out, input.
// R12: One of three global modes.
// R13: Unused product terms disabled, never reach sums.
// R14: Registered cell: common clock, OE pin, eight terms.
// R15: Comb cell: term-driven OE, seven terms; input disabled.
// R16: Register clear only at power-up, asynchronous.
`timescale 1ns/10ps
`default_nettype none
module pmcc_array
  import pmcc_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Dedicated inputs with external drive indication
  input wire logic [NUM_IN-1:0] in_pin,
  input wire logic [NUM_IN-1:0] in_drv,
  // Register clock and active-low output enable pins
  input wire logic clk_pin,
  input wire logic oe_n_pin,
  // Macrocell I/O pins
  input wire logic [NUM_MC-1:0] io_in,
  input wire logic [NUM_MC-1:0] io_drv,
  output logic [NUM_MC-1:0] io_out,
  output logic [NUM_MC-1:0] io_oe_n
);

  // Product term: AND of selected literals; a disabled term is forced low
  function automatic logic pt_eval(input logic [PT_W-1:0] mask, input logic en,
                                   input logic [PT_W-1:0] lit);
    pt_eval = en & (&(~mask | lit));
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    if (a == OFS_CTRL) begin
      is_mapped = 1'b1;
    end else if (a == OFS_MC_FUNC || a == OFS_PT_INDEX) begin
      is_mapped = 1'b1;
    end else if (a == OFS_PT_LO || a == OFS_PT_HI || a == OFS_PRELOAD) begin
      is_mapped = 1'b1;
    end else if (a == OFS_SIG_LO || a == OFS_SIG_HI || a == OFS_STATUS) begin
      is_mapped = 1'b1;
    end else begin
      is_mapped = 1'b0;
    end
  endfunction

  // Pin synchronisers
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic clk_prev_q;
  logic [NUM_IN-1:0] in_s;
  logic [NUM_IN-1:0] in_drv_s;
  logic clk_s;
  logic oe_n_s;
  logic [NUM_MC-1:0] io_s;
  logic [NUM_MC-1:0] io_drv_s;
  logic [NUM_IN-1:0] in_lvl;
  logic [NUM_MC-1:0] io_lvl;
  logic clk_rise;

  // Configuration and state
  logic [1:0] mode_q;
  logic secure_q;
  logic [15:0] mc_func_q;
  logic [PT_IDX_W-1:0] pt_idx_q;
  logic [PT_W-1:0] pt_mask_q [NUM_PT];
  logic [NUM_PT-1:0] pt_en_q;
  logic [63:0] sig_q;
  logic [NUM_MC-1:0] mc_q;
  logic [4:0] pwr_cnt_q;
  logic refused_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [NUM_MC-1:0] io_out_q;
  logic [NUM_MC-1:0] io_oe_n_q;

  // Array evaluation
  logic pwr_busy;
  pmcc_mode_t mode;
  logic [PT_W-1:0] lit;
  logic [NUM_LIT-1:0] fb;
  logic [NUM_PT-1:0] pt;
  logic [NUM_MC-1:0] out_d;
  logic [NUM_MC-1:0] oe_d;
  logic [NUM_MC-1:0] reg_cell;
  logic [NUM_MC-1:0] sum8;

  // Bus strobes
  logic wr_en;
  logic rd_setup;
  logic preload_wr;
  logic pt_read;
  logic [31:0] rd_data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      clk_prev_q <= 1'b0;
    end else if (ce) begin
      sync1_q <= {in_pin, in_drv, clk_pin, oe_n_pin, io_in, io_drv};
      sync2_q <= sync1_q;
      clk_prev_q <= clk_s;
    end
  end

  assign {in_s, in_drv_s, clk_s, oe_n_s, io_s, io_drv_s} = sync2_q;
  assign in_lvl = in_s | ~in_drv_s; // R10
  assign io_lvl = io_s | ~io_drv_s; // R10
  assign clk_rise = clk_s & ~clk_prev_q;

  // Power-up interval follows reset release; the clock pin is ignored meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_cnt_q <= '0;
    end else if (ce && pwr_busy) begin
      pwr_cnt_q <= pwr_cnt_q + 5'h1; // R3
    end
  end
  assign pwr_busy = (pwr_cnt_q < PWRUP_CYC); // R3

  // APB strobes; pready drops with ce so no transfer completes while frozen
  assign pready = ce;
  assign wr_en = psel & penable & pwrite & ce;
  assign rd_setup = psel & ~penable & ~pwrite & ce;
  assign preload_wr = wr_en & (paddr == OFS_PRELOAD);
  assign pt_read = rd_setup & (paddr == OFS_PT_LO || paddr == OFS_PT_HI);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RST;
      mc_func_q <= MC_FUNC_RST;
      pt_idx_q <= '0;
      sig_q <= SIG_RST;
    end else if (wr_en) begin
      if (paddr == OFS_CTRL) begin
        mode_q <= pwdata[CTRL_MODE_LSB +: 2]; // R12
      end else if (paddr == OFS_MC_FUNC) begin
        mc_func_q <= pwdata[15:0]; // R11
      end else if (paddr == OFS_PT_INDEX) begin
        pt_idx_q <= pwdata[PT_IDX_W-1:0];
      end else if (paddr == OFS_SIG_LO && !secure_q) begin
        sig_q[31:0] <= pwdata;
      end else if (paddr == OFS_SIG_HI && !secure_q) begin
        sig_q[63:32] <= pwdata;
      end
    end
  end

  // Security bit: set only, effective from the next cycle on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secure_q <= 1'b0;
    end else if (wr_en && paddr == OFS_CTRL && pwdata[CTRL_SECURE_BIT]) begin
      secure_q <= 1'b1; // R9
    end
  end

  // Fuse store has no reset: it models programmed, non-volatile cells
  always_ff @(posedge pclk) begin
    if (wr_en && paddr == OFS_PT_LO) begin
      pt_mask_q[pt_idx_q][31:0] <= pwdata;
    end else if (wr_en && paddr == OFS_PT_HI) begin
      pt_mask_q[pt_idx_q][PT_W-1:32] <= pwdata[PT_W-33:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pt_en_q <= '0; // R13
    end else if (wr_en && paddr == OFS_PT_HI) begin
      pt_en_q[pt_idx_q] <= pwdata[PT_HI_EN_BIT]; // R13
    end
  end

  // Refused verify or preload is flagged; a new refusal beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_q <= 1'b0;
    end else if (secure_q && (preload_wr || pt_read)) begin
      refused_q <= 1'b1; // R8
    end else if (wr_en && paddr == OFS_STATUS && pwdata[ST_REFUSED_BIT]) begin
      refused_q <= 1'b0;
    end
  end

  always_comb begin
    rd_data = 32'h0;
    if (paddr == OFS_CTRL) begin
      rd_data[CTRL_MODE_LSB +: 2] = mode_q;
      rd_data[CTRL_SECURE_BIT] = secure_q;
    end else if (paddr == OFS_MC_FUNC) begin
      rd_data[15:0] = mc_func_q;
    end else if (paddr == OFS_PT_INDEX) begin
      rd_data[PT_IDX_W-1:0] = pt_idx_q;
    end else if (paddr == OFS_PT_LO && !secure_q) begin
      rd_data = pt_mask_q[pt_idx_q][31:0]; // R8
    end else if (paddr == OFS_PT_HI && !secure_q) begin
      rd_data[PT_W-33:0] = pt_mask_q[pt_idx_q][PT_W-1:32]; // R8
      rd_data[PT_HI_EN_BIT] = pt_en_q[pt_idx_q];
    end else if (paddr == OFS_PRELOAD) begin
      rd_data[NUM_MC-1:0] = mc_q;
    end else if (paddr == OFS_SIG_LO) begin
      rd_data = sig_q[31:0]; // R7
    end else if (paddr == OFS_SIG_HI) begin
      rd_data = sig_q[63:32]; // R7
    end else if (paddr == OFS_STATUS) begin
      rd_data[ST_SECURE_BIT] = secure_q;
      rd_data[ST_PWRUP_BIT] = pwr_busy;
      rd_data[ST_REFUSED_BIT] = refused_q;
    end
  end

  // Read data and error are captured in the setup cycle, so access has no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (ce && psel && !penable) begin
      prdata_q <= pwrite ? 32'h0 : rd_data;
      pslverr_q <= ~is_mapped(paddr);
    end
  end
  assign prdata = prdata_q;
  assign pslverr = pslverr_q & psel & penable;

  // Literals: dedicated inputs then feedback, true half low, complement high
  assign mode = pmcc_mode_t'(mode_q);
  always_comb begin
    fb = {NUM_LIT{1'b0}};
    fb[NUM_IN-1:0] = in_lvl;
    for (int i = 0; i < NUM_MC; i++) begin
      fb[NUM_IN+i] = reg_cell[i] ? mc_q[i] : io_lvl[i];
    end
    lit = {~fb, fb};
  end

  // Kept out of the output process so feedback does not loop through it
  always_comb begin
    for (int i = 0; i < NUM_MC; i++) begin
      reg_cell[i] = (mode == MODE_REGISTERED) &&
        (pmcc_func_t'(mc_func_q[2*i +: 2]) == FN_REG); // R11
    end
  end

  always_comb begin
    for (int p = 0; p < NUM_PT; p++) begin
      pt[p] = pt_eval(pt_mask_q[p], pt_en_q[p], lit); // R13
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_MC; i++) begin
      out_d[i] = 1'b0;
      oe_d[i] = 1'b0;
      sum8[i] = |pt[PT_PER_MC*i +: PT_PER_MC];
      case (mode) // R12
        MODE_REGISTERED: begin
          case (pmcc_func_t'(mc_func_q[2*i +: 2])) // R11
            FN_REG: begin
              out_d[i] = ~mc_q[i]; // R2
              oe_d[i] = ~oe_n_s; // R14
            end
            FN_COMB_IO, FN_COMB_OUT: begin
              out_d[i] = |pt[PT_PER_MC*i+1 +: PT_PER_MC-1]; // R15
              oe_d[i] = pt[PT_PER_MC*i]; // R15
            end
            default: begin
              oe_d[i] = 1'b0; // R15
            end
          endcase
        end
        MODE_COMPLEX: begin
          if (pmcc_func_t'(mc_func_q[2*i +: 2]) != FN_INPUT) begin
            out_d[i] = |pt[PT_PER_MC*i+1 +: PT_PER_MC-1];
            oe_d[i] = pt[PT_PER_MC*i];
          end
        end
        default: begin
          // Simple mode: no enable term, so all eight terms feed the sum
          if (pmcc_func_t'(mc_func_q[2*i +: 2]) != FN_INPUT) begin
            out_d[i] = sum8[i];
            oe_d[i] = 1'b1;
          end
        end
      endcase
    end
  end

  // Registers: cleared only by the power-up reset, loaded on clock pin rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_q <= '0; // R1 R16
    end else if (preload_wr && !secure_q) begin
      mc_q <= pwdata[NUM_MC-1:0]; // R6
    end else if (ce && clk_rise && !pwr_busy) begin // R4 R5
      for (int i = 0; i < NUM_MC; i++) begin
        if (reg_cell[i]) begin
          mc_q[i] <= sum8[i]; // R14
        end
      end
    end
  end

  // Pin drivers are registered; enable is active low, high after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_out_q <= '1; // R2
      io_oe_n_q <= '1;
    end else if (ce) begin
      io_out_q <= out_d;
      io_oe_n_q <= ~oe_d;
    end
  end
  assign io_out = io_out_q;
  assign io_oe_n = io_oe_n_q;

endmodule
`default_nettype wire

// [verif/pmcc_sva.sv]
/*
  Assertion checker for the macrocell array, bound to its ports.
  Assumes pmcc_pkg and that ce stays high while traffic runs.
*/
`timescale 1ns/10ps
`default_nettype none
module pmcc_sva
  import pmcc_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Pins
  input wire logic oe_n_pin,
  input wire logic [NUM_MC-1:0] io_out,
  input wire logic [NUM_MC-1:0] io_oe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr, rd, sec_q;
  logic [1:0] mode_q, fn0_q;
  logic [31:0] sig_q;
  logic [4:0] cnt_q;
  assign wr = psel & penable & pwrite & ce;
  assign rd = psel & penable & !pwrite & ce;
  // Shadow of the configuration, cell 0 only to keep it small
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_q <= 1'b0;
      mode_q <= MODE_RST;
      fn0_q <= MC_FUNC_RST[1:0];
      sig_q <= SIG_RST[31:0];
    end else if (wr) begin
      if (paddr == OFS_CTRL) begin
        mode_q <= pwdata[1:0];
        sec_q <= sec_q | pwdata[CTRL_SECURE_BIT];
      end
      if (paddr == OFS_MC_FUNC) fn0_q <= pwdata[1:0];
      if (paddr == OFS_SIG_LO && !sec_q) sig_q <= pwdata;
    end
  end
  // Saturates so it never wraps back into the busy window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 5'h00;
    else if (ce && cnt_q != 5'h1f) cnt_q <= cnt_q + 5'h01;
  end
  property p_pwr_out; $rose(presetn) |-> io_out == 8'hff; endproperty
  a_pwr_out: assert property (p_pwr_out) else $error("outputs low after reset");
  property p_pwr_oe; $rose(presetn) |-> (io_oe_n == 8'hff) [*3]; endproperty
  a_pwr_oe: assert property (p_pwr_oe) else $error("driver on after reset");
  property p_busy; rd && paddr == OFS_STATUS && cnt_q < 5'h0c |-> prdata[ST_PWRUP_BIT];
  endproperty
  a_busy: assert property (p_busy) else $error("power-up busy missing");
  property p_idle; rd && paddr == OFS_STATUS && cnt_q > 5'h12 |-> !prdata[ST_PWRUP_BIT];
  endproperty
  a_idle: assert property (p_idle) else $error("power-up busy too long");
  property p_sec_pt;
    rd && sec_q && (paddr == OFS_PT_LO || paddr == OFS_PT_HI) |-> prdata == 32'h0;
  endproperty
  a_sec_pt: assert property (p_sec_pt) else $error("secured term readable");
  property p_sec_st; rd && sec_q && paddr == OFS_STATUS |-> prdata[ST_SECURE_BIT];
  endproperty
  a_sec_st: assert property (p_sec_st) else $error("secure not at once");
  property p_sig; rd && paddr == OFS_SIG_LO |-> prdata == sig_q; endproperty
  a_sig: assert property (p_sig) else $error("signature mismatch");
  property p_oe_reg;
    (mode_q == 2'h2 && fn0_q == 2'h0 && $stable(oe_n_pin)) [*4] |-> io_oe_n[0] == oe_n_pin;
  endproperty
  a_oe_reg: assert property (p_oe_reg) else $error("enable pin ignored");
  property p_in_off; (fn0_q == 2'h3) [*2] |-> io_oe_n[0]; endproperty
  a_in_off: assert property (p_in_off) else $error("input cell drives");
  c_sec: cover property (rd && sec_q && paddr == OFS_PT_LO);
  c_reg: cover property (mode_q == 2'h2 && fn0_q == 2'h0 && !io_oe_n[0]);
  c_sig: cover property (rd && paddr == OFS_SIG_LO);
endmodule
`default_nettype wire

// [verif/pmcc_pins.sv]
/*
  Board model: dedicated inputs with pull-ups and the register clock.
  Assumes the bench asks for a clock pulse by a one-cycle tick.
*/
`timescale 1ns/10ps
`default_nettype none
module pmcc_pins (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests from the bench
  input wire logic [11:0] want_in,
  input wire logic [11:0] want_drv,
  input wire logic tick,
  // Board pins
  output logic [11:0] in_pin,
  output logic [11:0] in_drv,
  output logic clk_pin
);
  logic [4:0] age_q;
  logic [3:0] ph_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) age_q <= 5'h00;
    else if (age_q != 5'h1f) age_q <= age_q + 5'h01;
  end
  // Undriven lines float to the pull-up level, never to the last value
  always_ff @(posedge pclk) begin
    in_pin <= want_in | ~want_drv;
    in_drv <= want_drv;
  end
  // Clock held still past the worst power-up interval; data settle first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 4'h0;
      clk_pin <= 1'b0;
    end else begin
      if (ph_q != 4'h0) ph_q <= ph_q - 4'h1;
      else if (tick && age_q > 5'h19) ph_q <= 4'hc;
      clk_pin <= (ph_q > 4'h3 && ph_q < 4'h8);
    end
  end
endmodule
`default_nettype wire

// [verif/tb.sv]
/*
  Self-checking bench for the macrocell array over APB and its pins.
  Assumes pmcc_pins as the board and pmcc_sva bound to the array.
*/
`timescale 1ns/10ps
`default_nettype none
module tb
  import pmcc_pkg::*;
;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic oe_n_pin = 1, tick = 0, clk_pin, pready, pslverr, err;
  logic [7:0] paddr = '0, io_in = '0, io_drv = '0, io_out, io_oe_n;
  logic [11:0] want_in = '0, want_drv = '0, in_pin, in_drv;
  logic [31:0] pwdata = '0, prdata, r, v;
  int num_errors = 0, tests_run = 0;
  always #20 pclk = ~pclk;
  pmcc_array i_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .in_pin, .in_drv, .clk_pin, .oe_n_pin, .io_in, .io_drv,
    .io_out, .io_oe_n);
  pmcc_pins i_pins (.pclk, .presetn, .want_in, .want_drv, .tick, .in_pin, .in_drv,
    .clk_pin);
  function automatic logic pin_lvl(logic d, logic drv);
    return drv ? d : 1'b1;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Waits as long as the slave stalls; only the watchdog ends a hang
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    v = $urandom(4);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Look before the first edge that may reload the pin drivers
    @(negedge pclk);
    check(io_out, 8'hff);
    @(posedge pclk);
    apb(0, OFS_STATUS, 0);
    check(r[ST_PWRUP_BIT], 1'b1);
    repeat (20) @(posedge pclk);
    apb(0, OFS_STATUS, 0);
    check(r[ST_PWRUP_BIT], 1'b0);
    apb(0, OFS_MC_FUNC, 0);
    check(r[15:0], MC_FUNC_RST);
    apb(0, 8'h24, 0);
    check(err, 1'b1);
    for (int m = 0; m < 3; m++) begin
      apb(1, OFS_CTRL, m);
      apb(0, OFS_CTRL, 0);
      check(r[1:0], m[1:0]);
    end
    apb(1, OFS_MC_FUNC, 32'hfffc);
    apb(1, OFS_PT_INDEX, 0);
    apb(1, OFS_PT_LO, 1);
    apb(1, OFS_PT_HI, 32'h100);
    check(io_out[0], 1'b1);
    // Registered cell: preload, enable pin, then one clock load
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      oe_n_pin <= v[31];
      io_in <= v[7:0];
      io_drv <= v[15:8];
      apb(1, OFS_PRELOAD, v[7:0]);
      apb(0, OFS_PRELOAD, 0);
      check(r[7:0], v[7:0]);
      check(io_out[0], !v[0]);
      check(io_oe_n[0], v[31]);
      want_in <= v[31:20];
      want_drv <= v[19:8];
      tick <= 1'b1;
      @(posedge pclk);
      tick <= 1'b0;
      repeat (24) @(posedge pclk);
      check(io_out[0], !pin_lvl(v[20], v[8]));
    end
    apb(1, OFS_CTRL, 0);
    apb(1, OFS_MC_FUNC, 32'hfffe);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      want_in <= v[11:0];
      want_drv <= v[23:12];
      repeat (6) @(posedge pclk);
      check(io_out[0], pin_lvl(v[0], v[12]));
    end
    // Complex and registered modes: term 0 enables the pin, term 1 feeds the sum
    apb(1, OFS_PT_INDEX, 1);
    apb(1, OFS_PT_LO, 2);
    apb(1, OFS_PT_HI, 32'h100);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      apb(1, OFS_CTRL, 1 + (i & 1));
      want_in <= v[11:0];
      want_drv <= v[23:12];
      repeat (6) @(posedge pclk);
      check(io_oe_n[0], !pin_lvl(v[0], v[12]));
      check(io_out[0], pin_lvl(v[1], v[13]));
    end
    v = $urandom;
    apb(1, OFS_SIG_LO, v);
    apb(1, OFS_SIG_HI, ~v);
    apb(1, OFS_PRELOAD, 32'h5a);
    apb(1, OFS_CTRL, 32'h4);
    apb(0, OFS_STATUS, 0);
    check(r[ST_SECURE_BIT], 1'b1);
    apb(0, OFS_PT_LO, 0);
    check(r, 32'h0);
    apb(1, OFS_PRELOAD, 32'ha5);
    apb(0, OFS_PRELOAD, 0);
    check(r[7:0], 8'h5a);
    apb(0, OFS_STATUS, 0);
    check(r[ST_REFUSED_BIT], 1'b1);
    apb(0, OFS_SIG_LO, 0);
    check(r, v);
    apb(0, OFS_SIG_HI, 0);
    check(r, ~v);
    apb(1, OFS_STATUS, 32'h4);
    apb(0, OFS_STATUS, 0);
    check(r[ST_REFUSED_BIT], 1'b0);
    // Second power-up: registers clear, then a frozen enable stalls the interval
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, OFS_PRELOAD, 0);
    check(r[7:0], 8'h00);
    ce <= 1'b0;
    repeat (20) @(posedge pclk);
    check(pready, 1'b0);
    ce <= 1'b1;
    apb(0, OFS_STATUS, 0);
    check(r[2:0], 3'b010);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    tally_and_finish();
  end
endmodule
bind pmcc_array pmcc_sva i_sva (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .oe_n_pin, .io_out, .io_oe_n);
`default_nettype wire
